/* design/ptc_timer.sv */
// control register and counting logic of a lower/upper timer pair, apb slave
// Operation
// - counter_run starts and stops the lower timer, or the whole pair in wide mode.
// - with idle_halt set the timer stops during idle, otherwise it counts on.
// - with the external clock selected gate_accum_en is ignored.
// - on the internal clock gate_accum_en picks gated accumulation, else free counting.
// - prescale_sel divides the input clock by 1, 8, 64 or 256.
// - pair_wide_mode joins lower and upper timer into one 32-bit timer.
// - with pair_wide_mode clear both timers count independently on own settings.
// - clk_src_sel chooses instr_clock or the ext_clk_pin clock.
// - clk_src_sel one means pin rising edge, zero means internal clock.
// - in wide mode lower holds the low word, upper the high word, lower clock and gate drive.
// - in wide mode upper control is ignored and the match flags the upper interrupt bit.
//
// Chosen here: the APB slave port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "ptc_defs.svh"
module ptc_timer
	import ptc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic idle_mode,
	input wire logic ext_clk_pin,
	input wire logic gate_pin,
	input wire logic upper_ext_clk_pin,
	input wire logic upper_gate_pin,
	output logic irq
);
	logic [15:0] ctrl_q;
	logic [15:0] uctrl_q;
	logic [15:0] cnt_lo_q;
	logic [15:0] cnt_hi_q;
	logic [15:0] per_lo_q;
	logic [15:0] per_hi_q;
	logic [1:0] stat_q;
	logic [1:0] mask_q;
	logic [2:0] ext_s_q;
	logic [2:0] gate_s_q;
	logic [2:0] uext_s_q;
	logic [2:0] ugate_s_q;
	logic ext_lvl_q;
	logic gate_lvl_q;
	logic uext_lvl_q;
	logic ugate_lvl_q;
	logic wide;
	logic wr;
	logic rd_ok;
	logic tick_lo;
	logic tick_hi;
	logic match_lo;
	logic match_hi;
	logic match_wide;
	logic ev_lo;
	logic ev_hi;
	logic wr_ctrl;
	logic wr_uctrl;
	logic wr_cnt_lo;
	logic wr_cnt_hi;
	logic wr_per_lo;
	logic wr_per_hi;
	logic wr_stat;
	logic wr_mask;
	logic clr_lo;
	logic clr_hi;
	logic carry_lo;
	logic wrap_lo;
	logic wrap_hi;
	ptc_cfg_t cfg_lo;
	ptc_cfg_t cfg_hi;
	ptc_pins_t pins_lo;
	ptc_pins_t pins_hi;

	// control fields of a register image
	function automatic ptc_cfg_t ptc_cfg_of(input logic [15:0] r);
		ptc_cfg_t c;
		c.run = r[`PTC_BIT_RUN];
		c.idle_halt = r[`PTC_BIT_IDLE];
		c.gate_accum_en = r[`PTC_BIT_GATE];
		c.prescale_sel = r[`PTC_BIT_PS_HI:`PTC_BIT_PS_LO];
		c.clk_src_sel = r[`PTC_BIT_CS];
		return c;
	endfunction : ptc_cfg_of

	// write strobe for one register offset
	function automatic logic ptc_wr_hit(input logic w, input logic [11:0] a,
		input logic [11:0] off);
		return w && (a == off);
	endfunction : ptc_wr_hit

	// rising edge of a filtered pin: stages two and three high, level still low
	function automatic logic ptc_rise_of(input logic [2:0] s, input logic lvl);
		return s[1] && s[2] && !lvl;
	endfunction : ptc_rise_of

	// apb decode, zero wait states
	assign wr = psel && penable && pwrite;
	assign pready = 1'b1;
	always_comb begin
		unique case (paddr)
			`PTC_OFF_CTRL, `PTC_OFF_CNT_LO, `PTC_OFF_CNT_HI, `PTC_OFF_PER_LO,
			`PTC_OFF_PER_HI, `PTC_OFF_UCTRL, `PTC_OFF_STAT, `PTC_OFF_MASK: rd_ok = 1'b1;
			default: rd_ok = 1'b0;
		endcase
	end
	assign pslverr = psel && penable && !rd_ok;

	// one write strobe per register; unmapped offsets match none of them
	assign wr_ctrl = ptc_wr_hit(wr, paddr, `PTC_OFF_CTRL);
	assign wr_uctrl = ptc_wr_hit(wr, paddr, `PTC_OFF_UCTRL);
	assign wr_cnt_lo = ptc_wr_hit(wr, paddr, `PTC_OFF_CNT_LO);
	assign wr_cnt_hi = ptc_wr_hit(wr, paddr, `PTC_OFF_CNT_HI);
	assign wr_per_lo = ptc_wr_hit(wr, paddr, `PTC_OFF_PER_LO);
	assign wr_per_hi = ptc_wr_hit(wr, paddr, `PTC_OFF_PER_HI);
	assign wr_stat = ptc_wr_hit(wr, paddr, `PTC_OFF_STAT);
	assign wr_mask = ptc_wr_hit(wr, paddr, `PTC_OFF_MASK);

	// write-one-to-clear requests for the two sticky flags
	assign clr_lo = wr_stat && pwdata[`PTC_ST_LO];
	assign clr_hi = wr_stat && pwdata[`PTC_ST_HI];

	// lower pin synchronisers: a change counts once stages two and three agree
	// only stage two reads stage one, so a metastable first stage never fans out
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_s_q <= 3'h0;
			gate_s_q <= 3'h0;
		end else begin
			ext_s_q <= {ext_s_q[1:0], ext_clk_pin};
			gate_s_q <= {gate_s_q[1:0], gate_pin};
		end
	end

	// upper pin synchronisers, same depth so both timers see the same latency
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			uext_s_q <= 3'h0;
			ugate_s_q <= 3'h0;
		end else begin
			uext_s_q <= {uext_s_q[1:0], upper_ext_clk_pin};
			ugate_s_q <= {ugate_s_q[1:0], upper_gate_pin};
		end
	end

	// filtered lower pin levels; a one-cycle glitch never makes stages two and three agree
	// levels reset low, the idle level of both pins, so no false edge follows reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_lvl_q <= 1'b0;
			gate_lvl_q <= 1'b0;
		end else begin
			if (ext_s_q[1] == ext_s_q[2]) begin
				ext_lvl_q <= ext_s_q[2];
			end
			if (gate_s_q[1] == gate_s_q[2]) begin
				gate_lvl_q <= gate_s_q[2];
			end
		end
	end

	// filtered upper pin levels
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			uext_lvl_q <= 1'b0;
			ugate_lvl_q <= 1'b0;
		end else begin
			if (uext_s_q[1] == uext_s_q[2]) begin
				uext_lvl_q <= uext_s_q[2];
			end
			if (ugate_s_q[1] == ugate_s_q[2]) begin
				ugate_lvl_q <= ugate_s_q[2];
			end
		end
	end

	// lower control drives both halves in wide mode
	// the upper image still feeds its own prescaler, whose tick then goes unused
	assign wide = ctrl_q[`PTC_BIT_WIDE];
	assign cfg_lo = ptc_cfg_of(ctrl_q);
	assign cfg_hi = ptc_cfg_of(uctrl_q);

	// pin edge pulses and levels handed to each prescaler
	assign pins_lo.ext_rise = ptc_rise_of(ext_s_q, ext_lvl_q);
	assign pins_lo.gate = gate_lvl_q;
	assign pins_lo.idle = idle_mode;
	assign pins_hi.ext_rise = ptc_rise_of(uext_s_q, uext_lvl_q);
	assign pins_hi.gate = ugate_lvl_q;
	assign pins_hi.idle = idle_mode;

	// lower prescaler and count enable, also the enable of the pair in wide mode
	ptc_tick u_tick_lo (
		.pclk(pclk),
		.presetn(presetn),
		.cfg(cfg_lo),
		.pins(pins_lo),
		.tick(tick_lo)
	);

	// upper prescaler, used only while the halves count apart
	ptc_tick u_tick_hi (
		.pclk(pclk),
		.presetn(presetn),
		.cfg(cfg_hi),
		.pins(pins_hi),
		.tick(tick_hi)
	);

	// period matches, full 32 bits in wide mode
	assign match_lo = (cnt_lo_q == per_lo_q);
	assign match_hi = (cnt_hi_q == per_hi_q);
	assign match_wide = match_lo && match_hi;
	assign ev_lo = !wide && tick_lo && match_lo;
	assign ev_hi = wide ? (tick_lo && match_wide) : (tick_hi && match_hi);

	// roll-over and carry points of the two count words
	// a tick at the period value writes zero rather than the period plus one
	assign wrap_lo = wide ? match_wide : match_lo;
	assign wrap_hi = wide ? match_wide : match_hi;
	assign carry_lo = tick_lo && (cnt_lo_q == 16'hFFFF);

	// lower control register, unimplemented bits read zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= `PTC_CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl_q <= pwdata[15:0] & `PTC_CTRL_WMASK;
		end
	end

	// upper control register, kept but ignored while wide
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			uctrl_q <= `PTC_CTRL_RST;
		end else if (wr_uctrl) begin
			uctrl_q <= pwdata[15:0] & `PTC_UCTRL_WMASK;
		end
	end

	// lower period word
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			per_lo_q <= `PTC_PER_RST;
		end else if (wr_per_lo) begin
			per_lo_q <= pwdata[15:0];
		end
	end

	// upper period word, the high half of the 32-bit period in wide mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			per_hi_q <= `PTC_PER_RST;
		end else if (wr_per_hi) begin
			per_hi_q <= pwdata[15:0];
		end
	end

	// lower count word; a software write takes priority over a tick
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_lo_q <= 16'h0000;
		end else if (wr_cnt_lo) begin
			cnt_lo_q <= pwdata[15:0];
		end else if (tick_lo) begin
			if (wrap_lo) begin
				cnt_lo_q <= 16'h0000;
			end else begin
				cnt_lo_q <= cnt_lo_q + 16'h0001;
			end
		end
	end

	// upper count word: carry in wide mode, own tick otherwise
	// the period match outranks the carry so the pair restarts from zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_hi_q <= 16'h0000;
		end else if (wr_cnt_hi) begin
			cnt_hi_q <= pwdata[15:0];
		end else if (wide) begin
			if (tick_lo && wrap_hi) begin
				cnt_hi_q <= 16'h0000;
			end else if (carry_lo) begin
				cnt_hi_q <= cnt_hi_q + 16'h0001;
			end
		end else if (tick_hi) begin
			cnt_hi_q <= wrap_hi ? 16'h0000 : cnt_hi_q + 16'h0001;
		end
	end

	// sticky flags, write one to clear; a coincident event wins so no match is lost
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_q <= 2'h0;
		end else begin
			if (ev_lo) begin
				stat_q[`PTC_ST_LO] <= 1'b1;
			end else if (clr_lo) begin
				stat_q[`PTC_ST_LO] <= 1'b0;
			end
			if (ev_hi) begin
				stat_q[`PTC_ST_HI] <= 1'b1;
			end else if (clr_hi) begin
				stat_q[`PTC_ST_HI] <= 1'b0;
			end
		end
	end

	// interrupt mask, same layout as the status flags
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_q <= 2'h0;
		end else if (wr_mask) begin
			mask_q <= pwdata[1:0];
		end
	end

	// level interrupt while any unmasked flag is set
	assign irq = |(stat_q & mask_q);

	// read data
	always_comb begin
		unique case (paddr)
			`PTC_OFF_CTRL: prdata = {16'h0000, ctrl_q};
			`PTC_OFF_CNT_LO: prdata = {16'h0000, cnt_lo_q};
			`PTC_OFF_CNT_HI: prdata = {16'h0000, cnt_hi_q};
			`PTC_OFF_PER_LO: prdata = {16'h0000, per_lo_q};
			`PTC_OFF_PER_HI: prdata = {16'h0000, per_hi_q};
			`PTC_OFF_UCTRL: prdata = {16'h0000, uctrl_q};
			`PTC_OFF_STAT: prdata = {30'h00000000, stat_q};
			`PTC_OFF_MASK: prdata = {30'h00000000, mask_q};
			default: prdata = 32'h00000000;
		endcase
	end
endmodule : ptc_timer
`default_nettype wire

/* inc/ptc_defs.svh */
// offsets, field positions, write masks and reset values of the paired timer
`ifndef PTC_DEFS_SVH
`define PTC_DEFS_SVH
`define PTC_OFF_CTRL 12'h000
`define PTC_OFF_CNT_LO 12'h004
`define PTC_OFF_CNT_HI 12'h008
`define PTC_OFF_PER_LO 12'h00C
`define PTC_OFF_PER_HI 12'h010
`define PTC_OFF_UCTRL 12'h014
`define PTC_OFF_STAT 12'h018
`define PTC_OFF_MASK 12'h01C
`define PTC_BIT_RUN 15
`define PTC_BIT_IDLE 13
`define PTC_BIT_GATE 6
`define PTC_BIT_PS_HI 5
`define PTC_BIT_PS_LO 4
`define PTC_BIT_WIDE 3
`define PTC_BIT_CS 1
`define PTC_CTRL_WMASK 16'hA07A
`define PTC_UCTRL_WMASK 16'hA072
`define PTC_CTRL_RST 16'h0000
`define PTC_PER_RST 16'hFFFF
`define PTC_ST_LO 0
`define PTC_ST_HI 1
`endif

/* inc/ptc_pkg.sv */
// types shared by the paired timer files
package ptc_pkg;
	typedef struct packed {
		logic run;
		logic idle_halt;
		logic gate_accum_en;
		logic [1:0] prescale_sel;
		logic clk_src_sel;
	} ptc_cfg_t;
	typedef struct packed {
		logic ext_rise;
		logic gate;
		logic idle;
	} ptc_pins_t;
endpackage : ptc_pkg

/* design/ptc_tick.sv */
// prescaled count enable for one timer
`timescale 1ns/100ps
`default_nettype none
module ptc_tick
	import ptc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input var ptc_cfg_t cfg,
	input var ptc_pins_t pins,
	output logic tick
);
	logic [7:0] div_q;
	logic src;
	logic lim;

	// source pulse: pin edge, gated internal clock or free internal clock
	always_comb begin
		if (cfg.clk_src_sel) begin
			src = pins.ext_rise;
		end else if (cfg.gate_accum_en) begin
			src = pins.gate;
		end else begin
			src = 1'b1;
		end
		if (!cfg.run || (cfg.idle_halt && pins.idle)) begin
			src = 1'b0;
		end
	end

	// terminal count of the prescaler for 1, 8, 64, 256
	always_comb begin
		unique case (cfg.prescale_sel)
			2'b00: lim = (div_q == 8'h00);
			2'b01: lim = (div_q == 8'h07);
			2'b10: lim = (div_q == 8'h3F);
			2'b11: lim = (div_q == 8'hFF);
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_q <= 8'h00;
		end else if (!cfg.run) begin
			div_q <= 8'h00;
		end else if (src) begin
			div_q <= lim ? 8'h00 : div_q + 8'h01;
		end
	end

	assign tick = src && lim;
endmodule : ptc_tick
`default_nettype wire

/* tb/ptc_monitor.sv */
// concurrent checks on the paired timer ports
`timescale 1ns/100ps
`default_nettype none
module ptc_monitor (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic irq
);
	logic [15:0] ctrl_q;
	logic [1:0] mask_q;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_rd(a);
		psel && penable && !pwrite && paddr == a;
	endsequence
	sequence s_setup;
		psel && !penable;
	endsequence
	// mirror of control and mask writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= 16'h0000;
			mask_q <= 2'h0;
		end else if (psel && penable && pwrite) begin
			if (paddr == 12'h000) ctrl_q <= pwdata[15:0] & 16'hA07A;
			if (paddr == 12'h01C) mask_q <= pwdata[1:0];
		end
	end
	a_ctrl_readback: assert property (s_rd(12'h000) |-> prdata == {16'h0000, ctrl_q})
		else $error("control readback differs");
	a_upper_unused: assert property (s_rd(12'h014) |-> (prdata & 32'hFFFF5F8D) == 32'h0)
		else $error("upper control unused bits set");
	a_unmapped_err: assert property (psel && penable && paddr > 12'h01C |-> pslverr && prdata == 0)
		else $error("unmapped access not refused");
	a_mapped_ok: assert property (psel && penable && paddr < 12'h020 && paddr[1:0] == 2'h0 |-> !pslverr)
		else $error("mapped access refused");
	a_no_wait: assert property (s_setup ##1 psel && penable |-> pready)
		else $error("access phase stalled");
	a_mask_quiet: assert property (mask_q == 2'h0 |-> !irq)
		else $error("irq with all masked");
	a_irq_status: assert property (s_rd(12'h018) |-> irq == |(prdata[1:0] & mask_q))
		else $error("irq disagrees with status");
	a_reset_quiet: assert property ($rose(presetn) |-> !irq ##1 !irq)
		else $error("irq after reset");
endmodule : ptc_monitor
bind ptc_timer ptc_monitor u_mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pready, .pslverr, .irq);
`default_nettype wire

/* tb/paired_timer_control_test.sv */
// self-checking bench of the paired timer control block
`timescale 1ns/100ps
`default_nettype none
`include "ptc_defs.svh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fail_count++; \
	$display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module paired_timer_control_test;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, p, exp_v;
	logic pready, pslverr, irq, idle_mode = 0, ext_clk_pin = 0, gate_pin = 0;
	logic [31:0] expq[$];
	int fail_count = 0, compares = 0, cyc = 0;
	always #4 pclk = ~pclk;
	ptc_timer DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .idle_mode(idle_mode), .ext_clk_pin(ext_clk_pin),
		.gate_pin(gate_pin), .upper_ext_clk_pin(ext_clk_pin), .upper_gate_pin(gate_pin),
		.irq(irq));
	// external clock of period 8 cycles and the hang limit
	always @(posedge pclk) begin
		cyc++;
		if (cyc % 4 == 0) ext_clk_pin <= ~ext_clk_pin;
		if (cyc > 30000) begin
			fail_count++;
			summarize();
		end
	end
	// read data checked against the oldest note
	always @(posedge pclk) begin
		if (psel && penable && !pwrite && pready === 1'b1) begin
			exp_v = expq.pop_front();
			`CHK(prdata, exp_v)
		end
	end
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk) penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 0; penable <= 0;
		@(posedge pclk);
	endtask : xfer
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		xfer(1, a, d);
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [15:0] e);
		expq.push_back({16'h0000, e});
		xfer(0, a, 0);
	endtask : rd
	// run for exactly 512 cycles from zero and read the count back
	task automatic span(input logic [31:0] c, input logic [11:0] ca, input logic [31:0] e);
		wr(`PTC_OFF_CTRL, 0); wr(`PTC_OFF_UCTRL, 0); wr(`PTC_OFF_CNT_LO, 0); wr(`PTC_OFF_CNT_HI, 0);
		wr(ca, c);
		repeat (509) @(posedge pclk);
		wr(ca, 0);
		rd(`PTC_OFF_CNT_LO, e[15:0]);
		rd(`PTC_OFF_CNT_HI, e[31:16]);
	endtask : span
	task automatic irq_wait();
		for (int k = 0; k < 99 && irq !== 1'b1; k++) @(posedge pclk);
		`CHK(irq, 1'b1)
		wr(`PTC_OFF_CTRL, 0);
	endtask : irq_wait
	task automatic summarize();
		$display("counts: %0d compares, %0d mismatches", compares, fail_count);
		if (fail_count == 0 && compares > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : summarize
	initial begin
		void'($urandom(83271));
		repeat (6) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		rd(`PTC_OFF_CTRL, 0);
		rd(`PTC_OFF_PER_LO, 16'hFFFF);
		rd(12'h020, 0);
		p = $urandom;
		wr(`PTC_OFF_CTRL, p);
		rd(`PTC_OFF_CTRL, p[15:0] & 16'hA07A);
		wr(`PTC_OFF_UCTRL, ~p);
		rd(`PTC_OFF_UCTRL, ~p[15:0] & 16'hA072);
		$display("test registers done");
		for (int i = 0; i < 4; i++) span(32'h8000 | (i << 4), `PTC_OFF_CTRL, 512 >> (3 * i - (i == 3)));
		span(0, `PTC_OFF_CTRL, 0);
		idle_mode <= 1;
		span(32'hA000, `PTC_OFF_CTRL, 0);
		span(32'h8000, `PTC_OFF_CTRL, 512);
		idle_mode <= 0;
		span(32'h8040, `PTC_OFF_CTRL, 0);
		gate_pin <= 1;
		span(32'h8040, `PTC_OFF_CTRL, 512);
		gate_pin <= 0;
		span(32'h8042, `PTC_OFF_CTRL, 64);
		span(32'h8008, `PTC_OFF_CTRL, 512);
		span(32'h8000, `PTC_OFF_UCTRL, 32'h02000000);
		span(32'h8002, `PTC_OFF_UCTRL, 32'h00400000);
		$display("test counting done");
		wr(`PTC_OFF_CNT_LO, 32'hFFFF);
		wr(`PTC_OFF_CNT_HI, 0);
		wr(`PTC_OFF_CTRL, 32'h8008);
		repeat (5) @(posedge pclk);
		wr(`PTC_OFF_CTRL, 0);
		rd(`PTC_OFF_CNT_HI, 1);
		rd(`PTC_OFF_CNT_LO, 7);
		p = 4 + $urandom % 16;
		wr(`PTC_OFF_PER_LO, p); wr(`PTC_OFF_MASK, 3); wr(`PTC_OFF_CNT_LO, 0);
		wr(`PTC_OFF_CTRL, 32'h8000);
		irq_wait();
		rd(`PTC_OFF_STAT, 1);
		wr(`PTC_OFF_STAT, 1);
		rd(`PTC_OFF_STAT, 0);
		wr(`PTC_OFF_PER_HI, 0); wr(`PTC_OFF_CNT_LO, 0); wr(`PTC_OFF_CNT_HI, 0);
		wr(`PTC_OFF_CTRL, 32'h8008);
		irq_wait();
		wr(`PTC_OFF_MASK, 0);
		rd(`PTC_OFF_STAT, 2);
		$display("test match done");
		summarize();
	end
endmodule : paired_timer_control_test
`default_nettype wire
